/* File: hdl/hrs_i2c_slave.sv */
// Two-wire serial slave port: condition detection, address match, acks, byte moves.
// Assumes the master drives the serial clock; register bank sits on the user ports.
// Function
// - Works with a master serial clock of any rate up to 400 kHz.
// - Each byte is eight data bits plus a ninth acknowledge pulse.
// - One bit per clock; data stable while clock high, changes there are conditions.
// - Data falling with clock high is START; data rising with clock high is STOP.
// - Both lines rest high when the bus is idle.
// - Repeated START keeps the session and returns to address reception.
// - STOP ends the transfer anywhere, even within the START's clock-high pulse.
// - Address compared bit by bit; first mismatch makes the port ignore the transfer.
// - Own address is seven bits 1010111, most significant bit first.
// - Address byte lowest bit: 0 master writes, 1 master reads.
// - A matching address is acknowledged by pulling data low one clock.
// - In write direction each received byte gets data held low for pulse nine.
// - Read bytes shift out on master clock; master acks, ends with nack then STOP.
// - Data line is driven open drain only, and also sampled.
// - Ready interrupt raised after power-up; cleared by reading interrupt status.
// - Write carries address, register pointer byte, then data; pointer steps per byte.
// - Read pointer steps per byte sent, except it stays on the FIFO data register.
// - Interrupt pin is active low open drain, low while an interrupt pends.
`timescale 1ns/1ps
`default_nettype none
module hrs_i2c_slave
  import hrs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic int_n_o,
  output logic int_oe_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  output logic wr_valid_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o
);
  hrs_link_type lk;
  hrs_link_type next_lk;
  hrs_core_type r;
  hrs_core_type next_r;
  logic start;
  logic stop;
  logic bit_ev;
  logic scl_fall;
  logic bit_in;
  logic [7:0] byte_in;
  logic load;

  // Link side: every rising serial clock captures one data bit and flips a toggle
  always_comb
  begin
    next_lk.ev_tog = ~lk.ev_tog;
    next_lk.bit_val = sda_i;
  end

  always_ff @(posedge scl_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lk <= HRS_LINK_RST;
    else
      lk <= next_lk;
  end

  // Bit value is held a whole clock period, read once its toggle is synchronised
  assign bit_in = lk.bit_val;
  assign byte_in = {r.shreg[6:0], bit_in};
  assign bit_ev = r.tog_s ^ r.tog_d;
  assign scl_fall = r.scl_d & ~r.scl_s;
  assign start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
  assign stop = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;

  always_comb
  begin
    next_r = r;
    load = 1'b0;
    next_r.wr.valid = 1'b0;
    next_r.drv_low = 1'b0;
    next_r.scl_m = scl_i;
    next_r.scl_s = r.scl_m;
    next_r.scl_d = r.scl_s;
    next_r.sda_m = sda_i;
    next_r.sda_s = r.sda_m;
    next_r.sda_d = r.sda_s;
    next_r.tog_m = lk.ev_tog;
    next_r.tog_s = r.tog_m;
    next_r.tog_d = r.tog_s;
    case (r.state)
      HRS_IDLE:
      begin
        next_r.sda_oe = 1'b0;
      end
      HRS_ADDR:
      begin
        if (bit_ev)
        begin
          next_r.shreg = byte_in;
          if (r.cnt == HRS_LAST_BIT)
          begin
            next_r.rw = bit_in;
            next_r.first = ~bit_in;
            next_r.ack_seen = 1'b0;
            next_r.cnt = 3'h0;
            next_r.state = HRS_ACK;
          end
          else if (bit_in != HRS_DEV_ADDR[HRS_ADDR_MSB - r.cnt])
            next_r.state = HRS_IGNORE;
          else
            next_r.cnt = r.cnt + 3'h1;
        end
      end
      HRS_ACK:
      begin
        if (bit_ev)
          next_r.ack_seen = 1'b1;
        if (scl_fall && !r.ack_seen)
          next_r.sda_oe = 1'b1;
        else if (scl_fall && r.rw)
          load = 1'b1;
        else if (scl_fall)
        begin
          next_r.sda_oe = 1'b0;
          next_r.cnt = 3'h0;
          next_r.state = HRS_WR;
        end
      end
      HRS_WR:
      begin
        if (bit_ev)
        begin
          next_r.shreg = byte_in;
          next_r.cnt = r.cnt + 3'h1;
          if (r.cnt == HRS_LAST_BIT)
          begin
            next_r.ack_seen = 1'b0;
            next_r.state = HRS_ACK;
            if (r.first)
            begin
              next_r.ptr = byte_in;
              next_r.first = 1'b0;
            end
            else
            begin
              next_r.wr.valid = 1'b1;
              next_r.wr.addr = r.ptr;
              next_r.wr.data = byte_in;
              next_r.ptr = r.ptr + 8'h01;
            end
          end
        end
      end
      HRS_RD:
      begin
        if (scl_fall && r.cnt != 3'h0)
          next_r.sda_oe = ~r.tx[HRS_LAST_BIT - r.cnt];
        if (bit_ev)
        begin
          next_r.cnt = r.cnt + 3'h1;
          if (r.cnt == HRS_LAST_BIT)
          begin
            next_r.ack_seen = 1'b0;
            next_r.state = HRS_RACK;
            if (r.ptr != HRS_FIFO_DATA_REG)
              next_r.ptr = r.ptr + 8'h01;
          end
        end
      end
      HRS_RACK:
      begin
        if (scl_fall && !r.ack_seen)
          next_r.sda_oe = 1'b0;
        else if (scl_fall)
          load = 1'b1;
        if (bit_ev)
        begin
          next_r.ack_seen = 1'b1;
          if (bit_in)
            next_r.state = HRS_IGNORE;
        end
      end
      HRS_IGNORE:
      begin
        next_r.sda_oe = 1'b0;
      end
      default:
      begin
        next_r.state = HRS_IDLE;
      end
    endcase
    if (load)
    begin
      next_r.tx = rd_data_i;
      next_r.sda_oe = ~rd_data_i[7];
      next_r.cnt = 3'h0;
      next_r.state = HRS_RD;
      if (r.ptr == HRS_INT_STAT_REG)
        next_r.int_pend = 1'b0;
    end
    if (start)
    begin
      next_r.state = HRS_ADDR;
      next_r.cnt = 3'h0;
      next_r.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      next_r.state = HRS_IDLE;
      next_r.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= HRS_CORE_RST;
    else
      r <= next_r;
  end

  assign sda_o = r.drv_low;
  assign sda_oe_o = r.sda_oe;
  assign int_n_o = r.drv_low;
  assign int_oe_o = r.int_pend;
  assign rd_addr_o = r.ptr;
  assign wr_valid_o = r.wr.valid;
  assign wr_addr_o = r.wr.addr;
  assign wr_data_o = r.wr.data;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_addr_bad;
    r.state == HRS_ADDR && bit_ev && r.cnt != HRS_LAST_BIT && !start && !stop
      && bit_in != HRS_DEV_ADDR[HRS_ADDR_MSB - r.cnt];
  endsequence

  sequence s_fifo_byte_end;
    r.state == HRS_RD && bit_ev && r.cnt == HRS_LAST_BIT && !start && !stop
      && r.ptr == HRS_FIFO_DATA_REG;
  endsequence

  sequence s_ack_drive;
    r.state == HRS_ACK && !r.ack_seen && scl_fall && !start && !stop;
  endsequence

  sequence s_addr_good;
    r.state == HRS_ADDR && bit_ev && r.cnt != HRS_LAST_BIT && !start && !stop
      && bit_in == HRS_DEV_ADDR[HRS_ADDR_MSB - r.cnt];
  endsequence

  sequence s_addr_last;
    r.state == HRS_ADDR && bit_ev && r.cnt == HRS_LAST_BIT && !start && !stop;
  endsequence

  sequence s_byte_end;
    r.state == HRS_WR && bit_ev && r.cnt == HRS_LAST_BIT && !start && !stop;
  endsequence

  sequence s_rd_end;
    r.state == HRS_RD && bit_ev && r.cnt == HRS_LAST_BIT && !start && !stop;
  endsequence

  sequence s_ack_done;
    r.state == HRS_ACK && r.ack_seen && scl_fall && !r.rw && !start && !stop;
  endsequence

  sequence s_rack_fall;
    r.state == HRS_RACK && !r.ack_seen && scl_fall && !start && !stop;
  endsequence

  sequence s_rack_bit;
    r.state == HRS_RACK && bit_ev && !start && !stop;
  endsequence

  sequence s_load;
    load && !start && !stop;
  endsequence

  a_start_to_addr: assert property (start |=> r.state == HRS_ADDR)
    else $error("START did not enter address reception");
  a_stop_to_idle: assert property (stop |=> r.state == HRS_IDLE && !r.sda_oe)
    else $error("STOP did not release the bus");
  a_addr_mismatch: assert property (s_addr_bad |=> r.state == HRS_IGNORE)
    else $error("Address mismatch not ignored");
  a_ignore_release: assert property ((r.state == HRS_IGNORE) [*2] |-> !r.sda_oe)
    else $error("Data driven while ignoring");
  a_ack_pull: assert property (s_ack_drive |=> r.sda_oe ##1 r.state == HRS_ACK)
    else $error("Acknowledge not driven");
  a_ack_hold: assert property ($fell(r.sda_oe) && $past(r.state) == HRS_ACK
      |-> $past(r.ack_seen))
    else $error("Acknowledge released before ninth pulse");
  a_ack_bound: assert property (r.state == HRS_ACK && bit_ev |=> r.ack_seen)
    else $error("Ninth pulse not recorded");
  a_wr_ptr_step: assert property (r.wr.valid |-> r.ptr == r.wr.addr + 8'h01)
    else $error("Pointer did not advance after write");
  a_fifo_hold: assert property (s_fifo_byte_end |=> r.ptr == HRS_FIFO_DATA_REG)
    else $error("Pointer left the FIFO data register");
  a_int_clear: assert property (load && r.ptr == HRS_INT_STAT_REG && !start && !stop
      |=> !int_oe_o)
    else $error("Interrupt not cleared by status read");
  a_oe_states: assert property (r.sda_oe
      |-> r.state inside {HRS_ACK, HRS_RD, HRS_RACK})
    else $error("Data driven outside a byte phase");
  a_bit_single: assert property (bit_ev |=> !bit_ev)
    else $error("Bit event lasted more than one cycle");
  a_bit_capture: assert property (bit_ev && r.scl_s |-> bit_in == r.sda_s)
    else $error("Captured bit differs from the data level");
  a_addr_step: assert property (s_addr_good
      |=> r.state == HRS_ADDR && r.cnt == $past(r.cnt) + 3'h1)
    else $error("Matching address bit not accepted");
  a_rw_capture: assert property (s_addr_last |=> r.rw == $past(bit_in))
    else $error("Direction bit not captured");
  a_addr_ack: assert property (s_addr_last |=> r.state == HRS_ACK && !r.ack_seen)
    else $error("Matching address not followed by acknowledge");
  a_first_ptr: assert property (s_addr_last |=> r.first == !$past(bit_in))
    else $error("Pointer byte expectation wrong");
  a_wr_ninth: assert property (s_byte_end |=> r.state == HRS_ACK && !r.ack_seen)
    else $error("Received byte not followed by acknowledge pulse");
  a_ptr_load: assert property (s_byte_end ##0 r.first
      |=> r.ptr == $past(byte_in) && !r.wr.valid)
    else $error("Pointer byte not loaded");
  a_wr_data: assert property (s_byte_end ##0 !r.first
      |=> r.wr.valid && r.wr.data == $past(byte_in) && r.wr.addr == $past(r.ptr))
    else $error("Data byte not written to the pointer");
  a_wr_pulse: assert property (r.wr.valid |=> !r.wr.valid)
    else $error("Write strobe lasted more than one cycle");
  a_ack_done: assert property (s_ack_done |=> !r.sda_oe && r.state == HRS_WR)
    else $error("Write acknowledge not released after ninth pulse");
  a_rd_load: assert property (s_load |=> r.state == HRS_RD && r.cnt == 3'h0)
    else $error("Read byte not started");
  a_rd_msb: assert property (s_load |=> r.sda_oe != $past(rd_data_i[7]))
    else $error("First read bit driven wrong");
  a_rd_ninth: assert property (s_rd_end |=> r.state == HRS_RACK && !r.ack_seen)
    else $error("Sent byte not followed by acknowledge pulse");
  a_rd_ptr_step: assert property (s_rd_end ##0 r.ptr != HRS_FIFO_DATA_REG
      |=> r.ptr == $past(r.ptr) + 8'h01)
    else $error("Pointer did not advance after read");
  a_rd_release: assert property (s_rack_fall |=> !r.sda_oe)
    else $error("Data not released for master acknowledge");
  a_rd_nack: assert property (s_rack_bit ##0 bit_in |=> r.state == HRS_IGNORE)
    else $error("Master not-acknowledge did not end the read");
  a_rd_more: assert property (s_rack_bit ##0 !bit_in
      |=> r.state == HRS_RACK && r.ack_seen)
    else $error("Master acknowledge did not continue the read");
  a_idle_release: assert property (r.state == HRS_IDLE |-> !r.sda_oe)
    else $error("Data driven while idle");
  a_start_release: assert property (start |=> !r.sda_oe && r.cnt == 3'h0)
    else $error("START did not restart address reception");
  a_int_sticky: assert property (int_oe_o && !(load && r.ptr == HRS_INT_STAT_REG)
      |=> int_oe_o)
    else $error("Interrupt dropped without a status read");
  a_int_no_set: assert property (!int_oe_o |=> !int_oe_o)
    else $error("Ready interrupt raised again");
  a_sda_low_only: assert property (!sda_o)
    else $error("Data line driven high");
  a_int_low_only: assert property (!int_n_o)
    else $error("Interrupt pin driven high");
endmodule
`default_nettype wire

/* File: hdl/hrs_pkg.sv */
// Shared constants and types of the sensor two-wire slave port.
// Assumes a single system clock domain plus the master's serial clock.
package hrs_pkg;
  localparam logic [6:0] HRS_DEV_ADDR = 7'h57;
  localparam logic [7:0] HRS_INT_STAT_REG = 8'h00;
  localparam logic [7:0] HRS_FIFO_DATA_REG = 8'h07;
  localparam logic [7:0] HRS_PTR_RST = 8'h00;
  localparam logic [2:0] HRS_LAST_BIT = 3'h7;
  localparam logic [2:0] HRS_ADDR_MSB = 3'h6;
  localparam int HRS_SCL_MAX_KHZ = 400;
  localparam int HRS_SYS_MHZ = 100;
  localparam int HRS_SCL_PERIOD_NS = 1000000 / HRS_SCL_MAX_KHZ;
  localparam int HRS_SCL_PERIOD_CYC = (HRS_SCL_PERIOD_NS * HRS_SYS_MHZ) / 1000;

  typedef enum logic [2:0] {
    HRS_IDLE,
    HRS_ADDR,
    HRS_ACK,
    HRS_WR,
    HRS_RD,
    HRS_RACK,
    HRS_IGNORE
  } hrs_state_type;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } hrs_wr_type;

  typedef struct packed {
    logic ev_tog;
    logic bit_val;
  } hrs_link_type;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic tog_m;
    logic tog_s;
    logic tog_d;
    hrs_state_type state;
    logic [2:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic ack_seen;
    logic first;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic sda_oe;
    logic int_pend;
    logic drv_low;
    hrs_wr_type wr;
  } hrs_core_type;

  localparam hrs_link_type HRS_LINK_RST = '{ev_tog: 1'b0, bit_val: 1'b1};
  localparam hrs_core_type HRS_CORE_RST = '{
    scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
    sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
    tog_m: 1'b0, tog_s: 1'b0, tog_d: 1'b0,
    state: HRS_IDLE, cnt: 3'h0, shreg: 8'h00, rw: 1'b0,
    ack_seen: 1'b0, first: 1'b0, ptr: HRS_PTR_RST, tx: 8'h00,
    sda_oe: 1'b0, int_pend: 1'b1, drv_low: 1'b0,
    wr: '{valid: 1'b0, addr: 8'h00, data: 8'h00}
  };
endpackage

/* File: dv/hrs_i2c_master.sv */
// Bus master model: makes the serial clock, frames and moves bytes.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module hrs_i2c_master #(
  parameter int HALF_NS = 1250
) (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  localparam int QTR_NS = HALF_NS / 4;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic bit_x(input logic b, output logic r);
    #(QTR_NS);
    sda_low_o = !b;
    #(HALF_NS - QTR_NS);
    scl_o = 1'b1;
    #(HALF_NS);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start();
    #(QTR_NS);
    sda_low_o = 1'b0;
    #(HALF_NS - QTR_NS);
    scl_o = 1'b1;
    #(HALF_NS);
    sda_low_o = 1'b1;
    #(HALF_NS);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    #(QTR_NS);
    sda_low_o = 1'b1;
    #(HALF_NS - QTR_NS);
    scl_o = 1'b1;
    #(HALF_NS);
    sda_low_o = 1'b0;
    #(HALF_NS);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(nack, r);
  endtask
endmodule
`default_nettype wire

/* File: dv/test_sensor_i2c_slave_interface.sv */
// Bench for the two-wire slave port, with a bus master model.
// Assumes a register bank whose read data is the pointer xor 5a.
`timescale 1ns/1ps
`default_nettype none
module test_sensor_i2c_slave_interface
  import hrs_pkg::*;
;
  localparam logic [7:0] WA = {HRS_DEV_ADDR, 1'b0};
  localparam logic [7:0] RA = {HRS_DEV_ADDR, 1'b1};
  logic sys_clk_i, rst_n_i, scl, sda, sda_o, sda_oe, int_n, int_oe;
  logic m_low, wr_valid, quiet;
  logic [7:0] rd_addr, rd_data, wr_addr, wr_data;
  logic [15:0] wq [$];
  int errors, n_checks;
  assign sda = !(m_low || (sda_oe && !sda_o));
  assign rd_data = rd_addr ^ 8'h5a;
  hrs_i2c_slave dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .int_n_o(int_n), .int_oe_o(int_oe), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data));
  hrs_i2c_master #(.HALF_NS(1250)) m_u (.sda_i(sda), .scl_o(scl),
    .sda_low_o(m_low));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic fail(input string m);
    errors++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    n_checks++;
    if (g !== e)
      fail(m);
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    n_checks++;
    if (g !== e)
      fail(m);
  endtask
  task automatic chk_wr(input logic [15:0] e);
    n_checks++;
    if (wq.size() == 0 || wq.pop_front() !== e)
      fail("write");
  endtask
  always @(negedge sys_clk_i)
  begin
    if (wr_valid === 1'b1)
      wq.push_back({wr_addr, wr_data});
    if (quiet && sda_oe !== 1'b0)
      fail("drive after bad addr");
  end
  task automatic wsel(input logic [7:0] p);
    logic a;
    m_u.start();
    m_u.wr_byte(WA, a);
    chk1(a, 1'b1, "addr ack");
    m_u.wr_byte(p, a);
    chk1(a, 1'b1, "ptr ack");
  endtask
  task automatic rsel(input logic [7:0] p);
    logic a;
    wsel(p);
    m_u.start();
    m_u.wr_byte(RA, a);
    chk1(a, 1'b1, "read ack");
  endtask
  task automatic t_int();
    logic [7:0] b;
    chk1(int_oe, 1'b1, "int");
    chk1(int_n, 1'b0, "int lvl");
    rsel(HRS_INT_STAT_REG);
    m_u.rd_byte(1'b0, b);
    chk8(b, 8'h5a, "int byte");
    m_u.rd_byte(1'b1, b);
    chk8(b, 8'h5b, "next byte");
    m_u.stop();
    chk1(int_oe, 1'b0, "int clear");
  endtask
  task automatic t_write();
    logic a;
    wsel(8'h05);
    m_u.wr_byte(8'h3c, a);
    chk1(a, 1'b1, "data ack");
    m_u.wr_byte(8'hc3, a);
    chk1(a, 1'b1, "data ack");
    m_u.stop();
    chk_wr(16'h053c);
    chk_wr(16'h06c3);
    chk8(rd_addr, 8'h07, "ptr");
  endtask
  task automatic t_fifo();
    logic [7:0] b;
    rsel(HRS_FIFO_DATA_REG);
    for (int i = 0; i < 3; i++)
    begin
      m_u.rd_byte(i == 2, b);
      chk8(b, HRS_FIFO_DATA_REG ^ 8'h5a, "fifo");
    end
    m_u.stop();
    chk8(rd_addr, HRS_FIFO_DATA_REG, "fifo ptr");
  endtask
  task automatic t_bad();
    logic a;
    logic [7:0] bad [3] = '{8'h2e, 8'hac, 8'hd7};
    foreach (bad[i])
    begin
      m_u.start();
      quiet = 1'b1;
      m_u.wr_byte(bad[i], a);
      chk1(a, 1'b0, "bad addr");
      m_u.wr_byte(8'h00, a);
      chk1(a, 1'b0, "after bad");
      quiet = 1'b0;
      m_u.stop();
    end
    chk1(wq.size() == 0, 1'b1, "stray write");
  endtask
  task automatic t_early();
    logic r;
    logic [7:0] b;
    wsel(8'h10);
    m_u.bit_x(1'b1, r);
    m_u.bit_x(1'b0, r);
    m_u.stop();
    chk1(wq.size() == 0, 1'b1, "partial");
    m_u.start();
    m_u.wr_byte(RA, r);
    chk1(r, 1'b1, "read ack");
    m_u.rd_byte(1'b1, b);
    m_u.stop();
    chk8(b, 8'h10 ^ 8'h5a, "early ptr");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #(950000);
    fail("timeout");
    results();
  end
  initial
  begin
    errors = 0;
    n_checks = 0;
    quiet = 1'b0;
    rst_n_i = 1'b0;
    repeat (16) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    chk1(sda_oe, 1'b0, "idle");
    chk8(rd_addr, HRS_PTR_RST, "ptr rst");
    repeat (4) @(negedge sys_clk_i);
    t_int();
    $display("t_int done");
    t_write();
    $display("t_write done");
    t_fifo();
    $display("t_fifo done");
    t_bad();
    $display("t_bad done");
    t_early();
    $display("t_early done");
    results();
  end
endmodule
`default_nettype wire
